/* lcdr_regs.vh */
// constants for the display driver two-wire slave receiver
// assumes the includer runs on one 200 MHz logic clock
`ifndef LCDR_REGS_VH
`define LCDR_REGS_VH

// ==========================================================
// slave address byte layout
`define LCDR_ADDR_FIXED     6'h1c
`define LCDR_ADDR_FIXED_HI  7
`define LCDR_ADDR_FIXED_LO  2
`define LCDR_ADDR_SEL_BIT   1
`define LCDR_ADDR_DIR_BIT   0

// ==========================================================
// byte framing
`define LCDR_BYTE_BITS      4'h8
`define LCDR_CONT_BIT       7

// ==========================================================
// display pointer and subaddress widths and reset values
`define LCDR_PTR_W          5
`define LCDR_PTR_LAST       5'h1f
`define LCDR_PTR_RST        5'h00
`define LCDR_SUB_W          3
`define LCDR_SUB_RST        3'h0

// ==========================================================
// synchroniser reset levels: scl, sda idle high, straps low
`define LCDR_SYNC_W         6
`define LCDR_SYNC_RST       6'h03

`endif

/* lcdr_sync.v */
// three-stage input synchroniser with agreement filter
// assumes inputs are asynchronous to clock
`timescale 1ns/1ps

module lcdr_sync #(
    parameter             WIDTH   = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input  wire             clock,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] level_out
);

// ==========================================================
// stages
reg [WIDTH-1:0] s1_ff;
reg [WIDTH-1:0] s2_ff;
reg [WIDTH-1:0] s3_ff;
reg [WIDTH-1:0] lvl_ff;

genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
        // s1 feeds s2 only; level moves once s2 and s3 agree
        always @(posedge clock) begin
            if (rst) begin
                s1_ff[i]  <= RST_VAL[i];
                s2_ff[i]  <= RST_VAL[i];
                s3_ff[i]  <= RST_VAL[i];
                lvl_ff[i] <= RST_VAL[i];
            end else begin
                s1_ff[i] <= async_in[i];
                s2_ff[i] <= s1_ff[i];
                s3_ff[i] <= s2_ff[i];
                if (s2_ff[i] == s3_ff[i]) begin
                    lvl_ff[i] <= s3_ff[i];
                end
            end
        end
    end
endgenerate

assign level_out = lvl_ff;

endmodule // lcdr_sync

/* lcdr_i2c_rx.v */
// write-only two-wire slave receiver for a segment display driver
// assumes scl, sda and strap pins are asynchronous; sda is open
// drain, resolved outside from sda_out/sda_oe; the command decoder
// and display RAM sit outside and use the strobes below
`timescale 1ns/1ps
`include "lcdr_regs.vh"

module lcdr_i2c_rx #(
    parameter PTR_W = `LCDR_PTR_W
) (
    input  wire             clock,
    input  wire             rst,
    input  wire             scl_pin,
    input  wire             sda_pin,
    input  wire             slave_addr_select_pin,
    input  wire             hw_subaddr_in_bit0,
    input  wire             hw_subaddr_in_bit1,
    input  wire             hw_subaddr_in_bit2,
    input  wire             ptr_load,
    input  wire [PTR_W-1:0] ptr_load_val,
    input  wire             dev_sel_load,
    input  wire [2:0]       dev_sel_val,
    output wire             sda_out,
    output wire             sda_oe,
    output wire             bus_idle,
    output wire             cmd_strobe,
    output wire             cmd_last,
    output wire [7:0]       rx_byte,
    output wire             data_strobe,
    output wire             data_mine,
    output wire [PTR_W-1:0] data_ptr,
    output wire [2:0]       sub_cnt
);

// ==========================================================
// states
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_CMD  = 3'h2;
localparam [2:0] ST_DATA = 3'h3;
localparam [2:0] ST_SKIP = 3'h4;

localparam [PTR_W-1:0] PTR_LAST = {PTR_W{1'b1}};

// ==========================================================
// address match, used when the address byte completes
function addr_match;
    input [7:0] b;
    input       sel;
    begin
        addr_match =
            (b[`LCDR_ADDR_FIXED_HI:`LCDR_ADDR_FIXED_LO]
                == `LCDR_ADDR_FIXED) &&
            (b[`LCDR_ADDR_SEL_BIT] == sel) &&
            !b[`LCDR_ADDR_DIR_BIT];
    end
endfunction

// ==========================================================
// target match, used for the data byte acknowledge and for data_mine;
// one when the strapped subaddress is the selected one
function sub_match;
    input [2:0] pins;
    input [2:0] sel;
    begin
        sub_match = (pins == sel);
    end
endfunction

// ==========================================================
// input synchronisation
wire [`LCDR_SYNC_W-1:0] pins_lvl;

// straps ride the same pipeline so every input has one latency
lcdr_sync #(
    .WIDTH   (`LCDR_SYNC_W),
    .RST_VAL (`LCDR_SYNC_RST)
) u_sync (
    .clock     (clock),
    .rst       (rst),
    .async_in  ({hw_subaddr_in_bit2, hw_subaddr_in_bit1,
                 hw_subaddr_in_bit0, slave_addr_select_pin,
                 sda_pin, scl_pin}),
    .level_out (pins_lvl)
);

wire       scl_lvl = pins_lvl[0];
wire       sda_lvl = pins_lvl[1];
wire       sa_lvl  = pins_lvl[2];
wire [2:0] hw_sub  = pins_lvl[5:3];

// ==========================================================
// edge and condition detection
// previous levels reset to idle high, so reset shows no false edge
reg scl_prev_ff;
reg sda_prev_ff;

always @(posedge clock) begin
    if (rst) begin
        scl_prev_ff <= 1'b1;
        sda_prev_ff <= 1'b1;
    end else begin
        scl_prev_ff <= scl_lvl;
        sda_prev_ff <= sda_lvl;
    end
end

wire scl_rise = scl_lvl & ~scl_prev_ff;
wire scl_fall = ~scl_lvl & scl_prev_ff;
// data moving while clock stays high is a condition, not a bit
wire start_cond = scl_lvl & scl_prev_ff & sda_prev_ff & ~sda_lvl;
wire stop_cond  = scl_lvl & scl_prev_ff & ~sda_prev_ff & sda_lvl;

// ==========================================================
// registers
reg [2:0]       state_ff;
reg [2:0]       nxt_state;
reg [3:0]       bit_cnt_ff;
reg [3:0]       nxt_bit_cnt;
reg [7:0]       shift_ff;
reg [7:0]       nxt_shift;
reg             ack_phase_ff;
reg             nxt_ack_phase;
reg             sda_oe_ff;
reg             nxt_sda_oe;
reg             cmd_strobe_ff;
reg             nxt_cmd_strobe;
reg             cmd_last_ff;
reg             nxt_cmd_last;
reg [7:0]       rx_byte_ff;
reg [7:0]       nxt_rx_byte;
reg             data_strobe_ff;
reg             nxt_data_strobe;
reg             data_mine_ff;
reg             nxt_data_mine;
reg [PTR_W-1:0] ptr_ff;
reg [PTR_W-1:0] nxt_ptr;
reg [2:0]       sub_ff;
reg [2:0]       nxt_sub;
reg             bus_idle_ff;
reg             sda_out_ff;

wire [7:0] full_byte = shift_ff;

// ==========================================================
// bit and byte events inside a frame
// start and stop need the clock high, so they never meet a fall
wire in_frame  = (state_ff != ST_IDLE);
wire bit_take  = scl_rise & ~ack_phase_ff &
                 (bit_cnt_ff != `LCDR_BYTE_BITS);
wire ack_done  = scl_fall & ack_phase_ff;
wire byte_done = scl_fall & ~ack_phase_ff &
                 (bit_cnt_ff == `LCDR_BYTE_BITS);
// data bytes count for every device, target or not
wire data_done = in_frame & byte_done & (state_ff == ST_DATA);

// ==========================================================
// receiver next state
always @* begin
    nxt_state       = state_ff;
    nxt_bit_cnt     = bit_cnt_ff;
    nxt_shift       = shift_ff;
    nxt_ack_phase   = ack_phase_ff;
    nxt_sda_oe      = sda_oe_ff;
    nxt_cmd_strobe  = 1'b0;
    nxt_cmd_last    = cmd_last_ff;
    nxt_rx_byte     = rx_byte_ff;
    nxt_data_strobe = 1'b0;
    nxt_data_mine   = data_mine_ff;

    if (start_cond) begin
        // repeated start also lands here
        nxt_state     = ST_ADDR;
        nxt_bit_cnt   = 4'h0;
        nxt_ack_phase = 1'b0;
        nxt_sda_oe    = 1'b0;
    end else if (stop_cond) begin
        nxt_state     = ST_IDLE;
        nxt_bit_cnt   = 4'h0;
        nxt_ack_phase = 1'b0;
        nxt_sda_oe    = 1'b0;
    end else if (in_frame) begin
        if (bit_take) begin
            nxt_shift   = {shift_ff[6:0], sda_lvl};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
        end else if (ack_done) begin
            // release after the ack clock; no byte count limit
            nxt_sda_oe    = 1'b0;
            nxt_ack_phase = 1'b0;
            nxt_bit_cnt   = 4'h0;
        end else if (byte_done) begin
            nxt_ack_phase = 1'b1;
            case (state_ff)
                ST_ADDR: begin
                    if (addr_match(full_byte, sa_lvl)) begin
                        nxt_sda_oe = 1'b1;
                        nxt_state  = ST_CMD;
                    end else begin
                        nxt_state  = ST_SKIP;
                    end
                end
                ST_CMD: begin
                    nxt_sda_oe     = 1'b1;
                    nxt_cmd_strobe = 1'b1;
                    nxt_rx_byte    = full_byte;
                    nxt_cmd_last   = !full_byte[`LCDR_CONT_BIT];
                    if (!full_byte[`LCDR_CONT_BIT]) begin
                        nxt_state = ST_DATA;
                    end
                end
                ST_DATA: begin
                    nxt_data_strobe = 1'b1;
                    nxt_rx_byte     = full_byte;
                    nxt_data_mine   = sub_match(hw_sub, sub_ff);
                    nxt_sda_oe      = sub_match(hw_sub, sub_ff);
                end
                default: begin
                    nxt_sda_oe = 1'b0;
                end
            endcase
        end
    end
end

// ==========================================================
// pointer and subaddress next state
always @* begin
    nxt_ptr = ptr_ff;
    nxt_sub = sub_ff;
    // loads come from the command decoder outside; a data byte
    // ending in the same cycle overrides a pointer load
    if (ptr_load) begin
        nxt_ptr = ptr_load_val;
    end
    if (dev_sel_load) begin
        nxt_sub = dev_sel_val;
    end
    if (data_done) begin
        // every device walks the pointer in step
        nxt_ptr = ptr_ff + {{(PTR_W-1){1'b0}}, 1'b1};
        if (ptr_ff == PTR_LAST) begin
            nxt_sub = sub_ff + 3'h1;
        end
    end
end

// ==========================================================
// framing registers
// the ack enable is dropped on every start or stop
always @(posedge clock) begin
    if (rst) begin
        state_ff     <= ST_IDLE;
        bit_cnt_ff   <= 4'h0;
        shift_ff     <= 8'h00;
        ack_phase_ff <= 1'b0;
        sda_oe_ff    <= 1'b0;
        sda_out_ff   <= 1'b0;
    end else begin
        state_ff     <= nxt_state;
        bit_cnt_ff   <= nxt_bit_cnt;
        shift_ff     <= nxt_shift;
        ack_phase_ff <= nxt_ack_phase;
        sda_oe_ff    <= nxt_sda_oe;
        // open drain: only ever pulls low
        sda_out_ff   <= 1'b0;
    end
end

// ==========================================================
// byte hand-over registers
always @(posedge clock) begin
    if (rst) begin
        cmd_strobe_ff  <= 1'b0;
        cmd_last_ff    <= 1'b0;
        rx_byte_ff     <= 8'h00;
        data_strobe_ff <= 1'b0;
        data_mine_ff   <= 1'b0;
    end else begin
        cmd_strobe_ff  <= nxt_cmd_strobe;
        cmd_last_ff    <= nxt_cmd_last;
        rx_byte_ff     <= nxt_rx_byte;
        data_strobe_ff <= nxt_data_strobe;
        data_mine_ff   <= nxt_data_mine;
    end
end

// ==========================================================
// pointer, subaddress and idle registers
always @(posedge clock) begin
    if (rst) begin
        ptr_ff      <= `LCDR_PTR_RST;
        sub_ff      <= `LCDR_SUB_RST;
        bus_idle_ff <= 1'b1;
    end else begin
        ptr_ff      <= nxt_ptr;
        sub_ff      <= nxt_sub;
        // idle also needs the receiver parked, so it stays low
        // from a start until the matching stop
        bus_idle_ff <= scl_lvl & sda_lvl & (nxt_state == ST_IDLE);
    end
end

// ==========================================================
// outputs, all registered
// sda_out is a flop tied low so the pad sees a clean level;
// the enable alone decides whether the line is pulled
assign sda_out     = sda_out_ff;
assign sda_oe      = sda_oe_ff;
assign bus_idle    = bus_idle_ff;
assign cmd_strobe  = cmd_strobe_ff;
assign cmd_last    = cmd_last_ff;
assign rx_byte     = rx_byte_ff;
assign data_strobe = data_strobe_ff;
assign data_mine   = data_mine_ff;
assign data_ptr    = ptr_ff;
assign sub_cnt     = sub_ff;

endmodule // lcdr_i2c_rx

/* lcdr_rx_chk_props.sv */
// concurrent checks on the two-wire display receiver top ports
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module lcdr_rx_chk #(
    parameter PTR_W = 5
) (
    input wire             clock,
    input wire             rst,
    input wire             scl_pin,
    input wire             sda_out,
    input wire             sda_oe,
    input wire             bus_idle,
    input wire             cmd_strobe,
    input wire             data_strobe,
    input wire             data_mine,
    input wire [PTR_W-1:0] data_ptr,
    input wire [2:0]       sub_cnt
);
    wire [PTR_W-1:0] ptr_inc = data_ptr + 1'b1;
    wire [2:0]       sub_inc = sub_cnt + 1'b1;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ==========================================================
    // acknowledge timing, idle flag, strobes and pointer stepping
    sequence ack_end;
        $fell(scl_pin) && sda_oe;
    endsequence
    idle_lines_a: assert property (!scl_pin [*6] |-> !bus_idle)
        else $error("idle flag up while clock line low");
    oe_open_a: assert property (sda_oe |-> !sda_out && !bus_idle)
        else $error("data line driven high or while idle");
    oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_pin)
        else $error("ack started during clock high");
    oe_hold_a: assert property (ack_end |-> sda_oe [*4])
        else $error("ack dropped too early");
    oe_release_a: assert property (ack_end |-> ##[4:10] !sda_oe)
        else $error("ack held beyond ninth clock");
    cmd_ack_a: assert property (cmd_strobe |-> ##[0:2] sda_oe)
        else $error("command byte not acknowledged");
    data_nack_a: assert property (data_strobe && !data_mine |->
        !sda_oe [*3])
        else $error("foreign data byte acknowledged");
    strobe_once_a: assert property (cmd_strobe |=> !cmd_strobe)
        else $error("command strobe longer than one cycle");
    ptr_step_a: assert property (data_strobe |-> data_ptr == $past(ptr_inc))
        else $error("pointer did not step on data byte");
    sub_wrap_a: assert property (data_strobe && $past(&data_ptr) |->
        sub_cnt == $past(sub_inc))
        else $error("subaddress did not step on pointer wrap");
endmodule // lcdr_rx_chk

bind lcdr_i2c_rx lcdr_rx_chk #(.PTR_W(PTR_W)) u_chk (
    .clock(clock), .rst(rst), .scl_pin(scl_pin), .sda_out(sda_out),
    .sda_oe(sda_oe), .bus_idle(bus_idle), .cmd_strobe(cmd_strobe),
    .data_strobe(data_strobe), .data_mine(data_mine),
    .data_ptr(data_ptr), .sub_cnt(sub_cnt));

/* lcdr_mst_model.sv */
// bus master model: drives clock line, pulls data line low
// assumes a pull-up on the data line and the design's ack enable
`timescale 1ns/1ps
module lcdr_mst_model #(
    parameter HALF = 8
) (
    input  wire clock,
    input  wire sda_oe,
    input  wire sda_out,
    output reg  scl_pin,
    output wire sda_pin
);
    reg     drv_low_ff = 1'b0;
    integer slow = 0;
    // released line floats back to the pull-up level
    assign sda_pin = !(drv_low_ff || (sda_oe && !sda_out));
    initial scl_pin = 1'b1;
    task wt(input integer n);
        begin
            repeat (n) @(posedge clock);
        end
    endtask
    task start;
        begin
            drv_low_ff <= 1'b0;
            wt(HALF / 2);
            scl_pin <= 1'b1;
            wt(HALF);
            drv_low_ff <= 1'b1;
            wt(HALF);
            scl_pin <= 1'b0;
        end
    endtask
    task stop;
        begin
            wt(HALF / 2);
            drv_low_ff <= 1'b1;
            wt(HALF / 2);
            scl_pin <= 1'b1;
            wt(HALF);
            drv_low_ff <= 1'b0;
            wt(HALF);
        end
    endtask
    // data only moves in the low phase; slow stretches it
    task bitx(input b, output r);
        begin
            wt(HALF / 2);
            drv_low_ff <= !b;
            wt(HALF / 2 + slow);
            scl_pin <= 1'b1;
            wt(HALF / 2);
            r = sda_pin;
            wt(HALF / 2);
            scl_pin <= 1'b0;
        end
    endtask
    task wr_byte(input [7:0] b, output ack);
        reg     r;
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) bitx(b[i], r);
            bitx(1'b1, r);
            ack = !r;
        end
    endtask
endmodule // lcdr_mst_model

/* lcdr_i2c_rx_tb.sv */
// self-checking bench for the two-wire display receiver
// assumes the master model and the bound checker are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
    failures = failures + 1; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module lcdr_i2c_rx_tb;
    reg         clock, rst, sel_pin, ptr_load, dev_sel_load, ack;
    reg  [2:0]  hw, dev_val, sub_cnt_w;
    reg  [4:0]  ptr_val;
    reg  [31:0] rnd = 32'h72aa;
    reg  [7:0]  cq[$], dq[$];
    wire        scl, sda, sda_out, sda_oe, bus_idle, cmd_strobe, cmd_last;
    wire        data_strobe, data_mine;
    wire [7:0]  rx_byte;
    wire [4:0]  data_ptr;
    wire [2:0]  sub_cnt;
    integer     failures = 0, n_tests = 0, m_ptr = 0, m_sub = 0, k;
    lcdr_i2c_rx uut (.clock(clock), .rst(rst), .scl_pin(scl),
        .sda_pin(sda), .slave_addr_select_pin(sel_pin),
        .hw_subaddr_in_bit0(hw[0]), .hw_subaddr_in_bit1(hw[1]),
        .hw_subaddr_in_bit2(hw[2]), .ptr_load(ptr_load),
        .ptr_load_val(ptr_val), .dev_sel_load(dev_sel_load),
        .dev_sel_val(dev_val), .sda_out(sda_out), .sda_oe(sda_oe),
        .bus_idle(bus_idle), .cmd_strobe(cmd_strobe), .cmd_last(cmd_last),
        .rx_byte(rx_byte), .data_strobe(data_strobe),
        .data_mine(data_mine), .data_ptr(data_ptr), .sub_cnt(sub_cnt));
    lcdr_mst_model mst (.clock(clock), .sda_oe(sda_oe),
        .sda_out(sda_out), .scl_pin(scl), .sda_pin(sda));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    // ==========================================================
    // reference model: queues of expected bytes, pointer, subaddress
    always @(posedge clock) begin
        if (cmd_strobe) begin
            `CHK(rx_byte, cq[0])
            `CHK(cmd_last, ~cq[0][7])
            void'(cq.pop_front());
        end
        if (data_strobe) begin
            `CHK(rx_byte, dq[0])
            `CHK(data_mine, m_sub == hw)
            void'(dq.pop_front());
            m_ptr = (m_ptr + 1) % 32;
            if (m_ptr == 0) m_sub = (m_sub + 1) % 8;
            `CHK(data_ptr, m_ptr[4:0])
            `CHK(sub_cnt, m_sub[2:0])
        end
    end
    task load(input [4:0] p, input [2:0] s);
        begin
            @(posedge clock);
            ptr_load <= 1'b1;
            ptr_val <= p;
            dev_sel_load <= 1'b1;
            dev_val <= s;
            @(posedge clock);
            ptr_load <= 1'b0;
            dev_sel_load <= 1'b0;
            m_ptr = p;
            m_sub = s;
        end
    endtask
    task xfer(input [7:0] ad, input integer nc, input integer nd, input ok);
        reg [7:0] b;
        reg       e;
        integer   i;
        begin
            mst.start;
            mst.wr_byte(ad, ack);
            `CHK(ack, ok)
            for (i = 0; i < nc + nd; i = i + 1) begin
                rnd = lfsr(rnd);
                b = rnd[7:0];
                if (i < nc) b[7] = (i < nc - 1);
                e = ok && (i < nc || m_sub == hw);
                if (ok && i < nc) cq.push_back(b);
                if (ok && i >= nc) dq.push_back(b);
                mst.wr_byte(b, ack);
                `CHK(ack, e)
            end
            `CHK(bus_idle, 1'b0)
            mst.stop;
            repeat (8) @(posedge clock);
            `CHK(bus_idle, 1'b1)
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #400000;
        failures = failures + 1;
        tally_and_finish;
    end
    initial begin
        rst = 1'b1;
        sel_pin = 1'b0;
        ptr_load = 1'b0;
        dev_sel_load = 1'b0;
        ptr_val = 5'h00;
        dev_val = 3'h0;
        rnd = lfsr(rnd);
        hw = rnd[2:0];
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (8) @(posedge clock);
        `CHK({bus_idle, sda_oe, data_ptr, sub_cnt}, 10'h200)
        load(5'h05, hw);
        xfer(8'h70, 2, 3, 1'b1);
        $display("scenario 1 done");
        load(5'h1e, hw);
        xfer(8'h70, 1, 4, 1'b1);
        $display("scenario 2 done");
        load(5'h00, hw + 3'h1);
        xfer(8'h70, 1, 2, 1'b1);
        $display("scenario 3 done");
        xfer(8'h72, 1, 1, 1'b0);
        xfer(8'h71, 1, 1, 1'b0);
        xfer(8'h50, 1, 1, 1'b0);
        $display("scenario 4 done");
        sel_pin <= 1'b1;
        load(5'h00, hw);
        xfer(8'h72, 1, 1, 1'b1);
        xfer(8'h70, 1, 1, 1'b0);
        $display("scenario 5 done");
        mst.slow = 16;
        mst.start;
        mst.wr_byte(8'h72, ack);
        for (k = 0; k < 3; k = k + 1) mst.bitx(1'b1, ack);
        xfer(8'h72, 2, 2, 1'b1);
        mst.slow = 0;
        $display("scenario 6 done");
        `CHK(cq.size() + dq.size(), 0)
        tally_and_finish;
    end
endmodule // lcdr_i2c_rx_tb
